// ===== verilog/fccfs_pkg.sv
// fccfs_pkg: register map, field positions and reset values of the
// fan-control configuration and fail-safe register bank.
// assumes an 8-bit register address space reached by the serial host port.
package fccfs_pkg;

    localparam logic [7:0] ADDR_CPU_LIMIT = 8'h3d;
    localparam logic [7:0] ADDR_VERSION = 8'h3f;
    localparam logic [7:0] ADDR_MAIN_CFG = 8'h40;

    localparam int START_BIT = 0;
    localparam int LOCK_BIT = 1;
    localparam int READY_BIT = 2;
    localparam int BOOST_BIT = 3;
    localparam int CPU_EN_BIT = 4;
    localparam int OT_MAN_BIT = 5;
    localparam int CPU_IF_BIT = 2;
    localparam int FAN4_BIT = 3;

    localparam logic [7:0] MAIN_CFG_RST = 8'h04;
    localparam logic [7:0] CPU_LIMIT_RST = 8'h00;
    localparam logic [7:0] CPU_LIMIT_OFF = 8'h80;
    localparam logic [7:0] DFLT_CPU_LIMIT = 8'h00;
    localparam logic [7:0] FULL_DUTY = 8'hff;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic [1:0] REV_EXT_CODE = 2'h3;

    typedef enum logic [1:0] {
        OVR_IDLE = 2'b01,
        OVR_ACTIVE = 2'b10
    } fccfs_ovr_t;

endpackage : fccfs_pkg

// ===== verilog/fccfs_duty_mux.sv
// fccfs_duty_mux: one pwm channel's final duty, full duty on override.
// assumes computed duty comes from the fan loop on the same clock.
`timescale 1ns/1ps
module fccfs_duty_mux (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic force_full_i,
    input wire logic [7:0] duty_i,
    output logic [7:0] duty_o
);

    // fans start at full duty out of reset, safest before limits exist
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            duty_o <= fccfs_pkg::FULL_DUTY;
        end else if (force_full_i) begin
            duty_o <= fccfs_pkg::FULL_DUTY;
        end else begin
            duty_o <= duty_i;
        end
    end

    chk_duty_select: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> duty_o == ($past(force_full_i) ? fccfs_pkg::FULL_DUTY
                                                : $past(duty_i)))
        else $error("pwm duty does not follow override selection");

endmodule : fccfs_duty_mux

// ===== verilog/fccfs_top.sv
// fccfs_top: configuration, version and cpu-limit fail-safe registers of
// a thermal monitor and fan controller, with the final pwm duty override.
// assumes a serial host interface decodes transfers into a one-cycle
// read or write strobe with address and data, all on clock_i.
`timescale 1ns/1ps
// Functional notes
// - once locked, lockable registers ignore writes and keep contents.
// - any cpu sensor reading above the cpu limit forces full duty.
// - a cpu limit of 0x80 disables the cpu-limit override.
// - override holds until temperature falls below limit minus hysteresis.
// - revision field reports silicon revision; all-ones points to extension.
// - version bit 2 always reads 1, cpu sensor interface present.
// - version bit 3 always reads 1, high frequency pwm configurable.
// - version upper nibble returns fixed family version code.
// - start 1 uses programmed limits; start 0 uses defaults, keeps programmed.
// - while start is cleared all pwm outputs run full duty.
// - start bit stays writable after lock.
// - lock is write-once; afterwards it and lockable limits stay fixed.
// - ready bit reads 1 once the device is up and monitoring.
// - boost forces full duty; clearing restores computed duty; writable locked.
// - cpu monitor enable turns on cpu sensing; read-only once locked.
// - override-in-manual bit extends overtemp/cpu-limit full duty to manual.
// - main configuration resets to 0x04, cpu limit to 0x00.
module fccfs_top #(
    parameter int NUM_PWM = 3,
    parameter int NUM_CPU = 4,
    parameter int SILICON_REV = 0,
    // arbitrary family code, not tied to any real part
    parameter logic [3:0] FAMILY_VERSION = 4'h9
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_en_i,
    input wire logic reg_rd_en_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [NUM_CPU-1:0][7:0] cpu_temp_i,
    input wire logic [NUM_CPU-1:0] cpu_temp_valid_i,
    input wire logic [3:0] cpu_hyst_i,
    input wire logic overtemp_input_i,
    input wire logic [NUM_PWM-1:0] pwm_auto_i,
    input wire logic [NUM_PWM-1:0][7:0] pwm_duty_i,
    output logic [7:0] reg_rdata_o,
    output logic [NUM_PWM-1:0][7:0] pwm_duty_o,
    output logic [7:0] eff_cpu_limit_o,
    output logic monitor_start_o,
    output logic cpu_sensor_enable_o,
    output logic cpu_override_o,
    output logic full_duty_o,
    output logic lock_o
);

    logic monitor_start_ff;
    logic lock_ff;
    logic ready_ff;
    logic fan_boost_ff;
    logic cpu_sensor_enable_ff;
    logic overtemp_override_in_manual_ff;
    logic [7:0] cpu_control_limit_ff;
    logic [7:0] eff_limit_ff;
    logic ot_meta_ff;
    logic ot_sync_ff;
    logic full_duty_ff;
    logic [7:0] rdata_ff;
    fccfs_pkg::fccfs_ovr_t ovr_state_ff;
    logic wr_limit;
    logic wr_cfg;
    logic [7:0] main_cfg_rd;
    logic [7:0] version_rd;
    logic [1:0] silicon_revision_field;
    logic [3:0] family_version_field;
    logic [7:0] active_limit;
    logic limit_off;
    logic any_over;
    logic all_below;
    logic signed [8:0] release_thr;
    logic cpu_ovr;
    logic ot_or_cpu;
    logic [NUM_PWM-1:0] force_full;
    fccfs_pkg::fccfs_ovr_t nxt_ovr_state;

    assign wr_limit = reg_wr_en_i && (reg_addr_i == fccfs_pkg::ADDR_CPU_LIMIT);
    assign wr_cfg = reg_wr_en_i && (reg_addr_i == fccfs_pkg::ADDR_MAIN_CFG);

    // start bit: never locked so software can always fall back to defaults
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            monitor_start_ff <= fccfs_pkg::MAIN_CFG_RST[fccfs_pkg::START_BIT];
        end else if (wr_cfg) begin
            monitor_start_ff <= reg_wdata_i[fccfs_pkg::START_BIT];
        end
    end

    // boost bit: stays writable under lock, an escape hatch for cooling
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            fan_boost_ff <= fccfs_pkg::MAIN_CFG_RST[fccfs_pkg::BOOST_BIT];
        end else if (wr_cfg) begin
            fan_boost_ff <= reg_wdata_i[fccfs_pkg::BOOST_BIT];
        end
    end

    // write-once lock: only a 0 to 1 transition, cleared by reset alone
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lock_ff <= fccfs_pkg::MAIN_CFG_RST[fccfs_pkg::LOCK_BIT];
        end else if (wr_cfg && !lock_ff) begin
            lock_ff <= reg_wdata_i[fccfs_pkg::LOCK_BIT];
        end
    end

    // lockable configuration bits
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cpu_sensor_enable_ff <=
                fccfs_pkg::MAIN_CFG_RST[fccfs_pkg::CPU_EN_BIT];
            overtemp_override_in_manual_ff <=
                fccfs_pkg::MAIN_CFG_RST[fccfs_pkg::OT_MAN_BIT];
        end else if (wr_cfg && !lock_ff) begin
            cpu_sensor_enable_ff <= reg_wdata_i[fccfs_pkg::CPU_EN_BIT];
            overtemp_override_in_manual_ff <=
                reg_wdata_i[fccfs_pkg::OT_MAN_BIT];
        end
    end

    // no power-up sequencing here: ready once reset has been released
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ready_ff <= fccfs_pkg::MAIN_CFG_RST[fccfs_pkg::READY_BIT];
        end else begin
            ready_ff <= 1'b1;
        end
    end

    // cpu control limit, lockable
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cpu_control_limit_ff <= fccfs_pkg::CPU_LIMIT_RST;
        end else if (wr_limit && !lock_ff) begin
            cpu_control_limit_ff <= reg_wdata_i;
        end
    end

    // programmed limit stays stored while the default one governs
    assign active_limit = monitor_start_ff ? cpu_control_limit_ff
                                           : fccfs_pkg::DFLT_CPU_LIMIT;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            eff_limit_ff <= fccfs_pkg::DFLT_CPU_LIMIT;
        end else begin
            eff_limit_ff <= active_limit;
        end
    end

    // overtemperature pin comes from outside the clock domain
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ot_meta_ff <= 1'b0;
            ot_sync_ff <= 1'b0;
        end else begin
            ot_meta_ff <= overtemp_input_i;
            ot_sync_ff <= ot_meta_ff;
        end
    end

    // temperatures and limit are two's complement degrees
    assign limit_off = (active_limit == fccfs_pkg::CPU_LIMIT_OFF);
    assign release_thr = $signed({active_limit[7], active_limit})
                       - $signed({5'h00, cpu_hyst_i});

    always_comb begin
        any_over = 1'b0;
        all_below = 1'b1;
        for (int i = 0; i < NUM_CPU; i++) begin
            if (cpu_temp_valid_i[i]) begin
                if ($signed(cpu_temp_i[i]) > $signed(active_limit)) begin
                    any_over = 1'b1;
                end
                if (!($signed({cpu_temp_i[i][7], cpu_temp_i[i]})
                      < release_thr)) begin
                    all_below = 1'b0;
                end
            end
        end
    end

    // cpu-limit override with hysteresis; sensing off means no override
    always_comb begin
        nxt_ovr_state = ovr_state_ff;
        unique case (ovr_state_ff)
            fccfs_pkg::OVR_IDLE: begin
                if (cpu_sensor_enable_ff && !limit_off && any_over) begin
                    nxt_ovr_state = fccfs_pkg::OVR_ACTIVE;
                end
            end
            fccfs_pkg::OVR_ACTIVE: begin
                if (!cpu_sensor_enable_ff || limit_off || all_below) begin
                    nxt_ovr_state = fccfs_pkg::OVR_IDLE;
                end
            end
            default: begin
                nxt_ovr_state = fccfs_pkg::OVR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ovr_state_ff <= fccfs_pkg::OVR_IDLE;
        end else begin
            ovr_state_ff <= nxt_ovr_state;
        end
    end

    assign cpu_ovr = (ovr_state_ff == fccfs_pkg::OVR_ACTIVE);
    assign ot_or_cpu = cpu_ovr || ot_sync_ff;

    // manual or disabled channels only see overtemp when allowed to
    always_comb begin
        for (int c = 0; c < NUM_PWM; c++) begin
            force_full[c] = fan_boost_ff || !monitor_start_ff
                || (ot_or_cpu && (pwm_auto_i[c]
                    || overtemp_override_in_manual_ff));
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_PWM; g++) begin : g_pwm
            fccfs_duty_mux u_duty (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .force_full_i(force_full[g]),
                .duty_i(pwm_duty_i[g]),
                .duty_o(pwm_duty_o[g])
            );
        end
    endgenerate

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            full_duty_ff <= 1'b1;
        end else begin
            full_duty_ff <= &force_full;
        end
    end

    // revision above the field's range saturates at the extension code
    assign silicon_revision_field = (SILICON_REV >= 3) ? fccfs_pkg::REV_EXT_CODE
                                  : 2'(SILICON_REV);
    assign family_version_field = FAMILY_VERSION;

    always_comb begin
        version_rd = {family_version_field, 2'b00, silicon_revision_field};
        version_rd[fccfs_pkg::CPU_IF_BIT] = 1'b1;
        version_rd[fccfs_pkg::FAN4_BIT] = 1'b1;
    end

    // reserved bits 7:6 read as zero
    always_comb begin
        main_cfg_rd = 8'h00;
        main_cfg_rd[fccfs_pkg::START_BIT] = monitor_start_ff;
        main_cfg_rd[fccfs_pkg::LOCK_BIT] = lock_ff;
        main_cfg_rd[fccfs_pkg::READY_BIT] = ready_ff;
        main_cfg_rd[fccfs_pkg::BOOST_BIT] = fan_boost_ff;
        main_cfg_rd[fccfs_pkg::CPU_EN_BIT] = cpu_sensor_enable_ff;
        main_cfg_rd[fccfs_pkg::OT_MAN_BIT] = overtemp_override_in_manual_ff;
    end

    // read data is registered; it holds until the next read strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_ff <= fccfs_pkg::UNMAPPED_DATA;
        end else if (reg_rd_en_i) begin
            unique case (reg_addr_i)
                fccfs_pkg::ADDR_CPU_LIMIT: rdata_ff <= cpu_control_limit_ff;
                fccfs_pkg::ADDR_VERSION: rdata_ff <= version_rd;
                fccfs_pkg::ADDR_MAIN_CFG: rdata_ff <= main_cfg_rd;
                default: rdata_ff <= fccfs_pkg::UNMAPPED_DATA;
            endcase
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign eff_cpu_limit_o = eff_limit_ff;
    assign monitor_start_o = monitor_start_ff;
    assign cpu_sensor_enable_o = cpu_sensor_enable_ff;
    assign cpu_override_o = cpu_ovr;
    assign full_duty_o = full_duty_ff;
    assign lock_o = lock_ff;

    chk_lock_limit_frozen: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        lock_ff && wr_limit |=> $stable(cpu_control_limit_ff))
        else $error("locked cpu limit changed on write");

    chk_lock_write_once: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        lock_ff |=> lock_ff && $stable(cpu_sensor_enable_ff)
                 && $stable(overtemp_override_in_manual_ff))
        else $error("lock or lockable bit changed after lock");

    chk_start_unlocked: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        wr_cfg |=> monitor_start_ff == $past(reg_wdata_i[0])
                && fan_boost_ff == $past(reg_wdata_i[3]))
        else $error("start or boost not written");

    chk_boost_full: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        fan_boost_ff |=> full_duty_ff && pwm_duty_o[0] == 8'hff)
        else $error("boost did not force full duty");

    chk_stop_full: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        !monitor_start_ff [*2] |-> full_duty_ff)
        else $error("start cleared without full duty");

    chk_limit_off: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        limit_off |=> !cpu_override_o)
        else $error("override active with limit disabled");

    chk_ovr_engage: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        cpu_sensor_enable_ff && !limit_off && any_over
        |=> cpu_ovr ##1 full_duty_ff || !overtemp_override_in_manual_ff)
        else $error("cpu limit exceeded without override");

    chk_ovr_hold: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        cpu_ovr && cpu_sensor_enable_ff && !limit_off && !all_below
        |=> cpu_ovr)
        else $error("override released above hysteresis");

    chk_version_read: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        reg_rd_en_i && reg_addr_i == 8'h3f
        |=> reg_rdata_o[3:2] == 2'h3 && reg_rdata_o[7:4] == FAMILY_VERSION)
        else $error("version register content wrong");

    chk_cfg_read: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        reg_rd_en_i && reg_addr_i == 8'h40
        |=> reg_rdata_o[7:6] == 2'h0 && reg_rdata_o[2])
        else $error("configuration readback wrong");

    chk_ot_manual: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ot_sync_ff && overtemp_override_in_manual_ff |=> full_duty_ff)
        else $error("overtemp in manual did not force full duty");

endmodule : fccfs_top

// ===== tb/fccfs_cpu_sensor_model.sv
// fccfs_cpu_sensor_model: cpu temperature sensors behind the sensor link.
// assumes the bench sets channel 0's reading; other channels sit cool.
`timescale 1ns/1ps
module fccfs_cpu_sensor_model #(
    parameter int NUM_CPU = 4
) (
    input wire logic clock_i,
    input wire logic enable_i,
    input wire logic [7:0] hot_temp_i,
    output logic [NUM_CPU-1:0][7:0] temp_o,
    output logic [NUM_CPU-1:0] valid_o
);
    initial begin
        temp_o = '0;
        valid_o = '0;
    end
    // unsensed lines toggle so a stale reading never passes for a live one
    always @(negedge clock_i) begin
        for (int i = 0; i < NUM_CPU; i++) begin
            if (enable_i) begin
                temp_o[i] <= (i == 0) ? hot_temp_i : 8'h20;
            end else begin
                temp_o[i] <= ~temp_o[i];
            end
        end
        valid_o <= {NUM_CPU{enable_i}};
    end
endmodule : fccfs_cpu_sensor_model

// ===== tb/tb.sv
// tb: self-checking bench for the configuration and fail-safe bank.
// assumes fccfs_pkg, the design and the sensor model compile first.
`timescale 1ns/1ps
module tb;
    localparam logic [3:0] FAM = 4'h5; // arbitrary family code
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] temp0 = 8'h20;
    logic [3:0] hyst = 4'h4;
    logic ot = 1'b0;
    logic [2:0] auto_en = 3'b111;
    logic [2:0][7:0] duty_in = {8'h33, 8'h22, 8'h11};
    logic [3:0][7:0] temps;
    logic [3:0] tvalid;
    logic [7:0] rdata;
    logic [7:0] eff;
    logic [2:0][7:0] duty;
    logic start, cpu_en, ovr, full, lock;
    int fails = 0;
    int checks = 0;

    always #50 clock_i = ~clock_i;

    fccfs_top #(.NUM_PWM(3), .NUM_CPU(4), .SILICON_REV(2),
        .FAMILY_VERSION(FAM)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_en_i(wr),
        .reg_rd_en_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .cpu_temp_i(temps), .cpu_temp_valid_i(tvalid), .cpu_hyst_i(hyst),
        .overtemp_input_i(ot), .pwm_auto_i(auto_en), .pwm_duty_i(duty_in),
        .reg_rdata_o(rdata), .pwm_duty_o(duty), .eff_cpu_limit_o(eff),
        .monitor_start_o(start), .cpu_sensor_enable_o(cpu_en),
        .cpu_override_o(ovr), .full_duty_o(full), .lock_o(lock));

    fccfs_cpu_sensor_model #(.NUM_CPU(4)) sens_u (
        .clock_i(clock_i), .enable_i(cpu_en), .hot_temp_i(temp0),
        .temp_o(temps), .valid_o(tvalid));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clock_i);
        wr = 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock_i);
        rd = 1'b1;
        addr = a;
        @(negedge clock_i);
        rd = 1'b0;
        chk(rdata, exp);
    endtask : rd_reg

    // mask bit set means that channel must run full duty
    task automatic chk_duty(input logic [2:0] mask);
        repeat (5) @(negedge clock_i);
        for (int i = 0; i < 3; i++) begin
            chk(duty[i], mask[i] ? 8'hff : duty_in[i]);
        end
    endtask : chk_duty

    task automatic t_reset;
        rd_reg(8'h40, 8'h04);
        rd_reg(8'h3d, 8'h00);
        rd_reg(8'h3f, {FAM, 2'b11, 2'h2});
        wr_reg(8'h3f, 8'h00);
        rd_reg(8'h3f, {FAM, 2'b11, 2'h2});
        rd_reg(8'h41, 8'h00);
        chk_duty(3'b111);
        chk({7'h0, full}, 8'h01);
        $display("test reset done");
    endtask : t_reset

    task automatic t_start;
        wr_reg(8'h3d, 8'h50);
        wr_reg(8'h40, 8'h01);
        rd_reg(8'h40, 8'h05);
        chk(eff, 8'h50);
        chk_duty(3'b000);
        chk({7'h0, full}, 8'h00);
        wr_reg(8'h40, 8'h00);
        chk_duty(3'b111);
        chk(eff, 8'h00);
        rd_reg(8'h3d, 8'h50);
        wr_reg(8'h40, 8'h09);
        chk_duty(3'b111);
        wr_reg(8'h40, 8'h01);
        chk_duty(3'b000);
        $display("test start and boost done");
    endtask : t_start

    task automatic t_cpu;
        wr_reg(8'h40, 8'h11);
        chk({7'h0, cpu_en}, 8'h01);
        auto_en = 3'b011;
        temp0 = 8'h51;
        chk_duty(3'b011);
        chk({7'h0, ovr}, 8'h01);
        temp0 = 8'h4c;
        chk_duty(3'b011);
        temp0 = 8'h4b;
        chk_duty(3'b000);
        chk({7'h0, ovr}, 8'h00);
        wr_reg(8'h40, 8'h31);
        temp0 = 8'h51;
        chk_duty(3'b111);
        temp0 = 8'h20;
        chk_duty(3'b000);
        ot = 1'b1;
        chk_duty(3'b111);
        ot = 1'b0;
        wr_reg(8'h3d, 8'h80);
        temp0 = 8'h7f;
        chk_duty(3'b000);
        chk({7'h0, ovr}, 8'h00);
        temp0 = 8'h20;
        $display("test cpu limit done");
    endtask : t_cpu

    // lock is permanent until reset, so this runs just before the mid-run reset test
    task automatic t_lock;
        wr_reg(8'h40, 8'h33);
        rd_reg(8'h40, 8'h37);
        chk({7'h0, lock}, 8'h01);
        wr_reg(8'h3d, 8'h40);
        rd_reg(8'h3d, 8'h80);
        wr_reg(8'h40, 8'h08);
        rd_reg(8'h40, 8'h3e);
        chk({7'h0, start}, 8'h00);
        chk({7'h0, cpu_en}, 8'h01);
        chk_duty(3'b111);
        wr_reg(8'h40, 8'h01);
        rd_reg(8'h40, 8'h37);
        $display("test lock done");
    endtask : t_lock

    // only a reset clears the lock; limits become writable again
    task automatic t_rerst;
        @(negedge clock_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        rd_reg(8'h40, 8'h04);
        rd_reg(8'h3d, 8'h00);
        chk({7'h0, full}, 8'h01);
        wr_reg(8'h3d, 8'h40);
        rd_reg(8'h3d, 8'h40);
        $display("test mid-run reset done");
    endtask : t_rerst

    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // tests take under 1000 cycles; a hang stops well after that
    initial begin
        repeat (5000) @(posedge clock_i);
        fails++;
        finish_test;
    end

    initial begin
        repeat (16) @(negedge clock_i);
        rst_n_i = 1'b1;
        t_reset;
        t_start;
        t_cpu;
        t_lock;
        t_rerst;
        finish_test;
    end
endmodule : tb
